//--- inc/coproc_xfer_regs.vh
`ifndef COPROC_XFER_REGS_VH
`define COPROC_XFER_REGS_VH
// Register byte offsets
`define A_PRIM 8'h00
`define A_CTRL 8'h04
`define A_EA 8'h08
`define A_SCAN 8'h0C
`define A_STAT 8'h10
`define A_INTST 8'h14
`define A_INTMSK 8'h18
`define A_STATE 8'h1C
// Primitive word fields
`define PR_REL 15
`define PR_AFW 14
`define PR_DIR 13
`define PR_CODE 12:8
`define PR_LEN 7:0
`define PR_SCAN 0
`define CODE_MULTI 5'h01
`define CODE_SRSC 5'h02
// Control register fields
`define CT_COND 0
`define CT_MODE 3:1
`define CT_EXT 6:4
// Addressing mode classes
`define M_CTLALT 3'h0
`define M_CTL 3'h1
`define M_POST 3'h2
`define M_PRE 3'h3
// Interface register selects
`define CIR_CTRL 2'h0
`define CIR_RSEL 2'h1
`define CIR_OPND 2'h2
`define CIR_IADR 2'h3
`define ABORT_MASK 32'h00000001
// Status word fields
`define SW_TRACE 15:14
`define SW_SUPER 13
`define TRACE_FLOW 2'h1
// Interrupt status bits
`define INT_DONE 0
`define INT_PV 1
`define INT_FL 2
`define INT_TR 3
// Reset values and step sizes
`define RST_W32 32'h00000000
`define RST_W16 16'h0000
`define STEP_L 8'h04
`define STEP_W 8'h02
`endif

//--- rtl/coproc_transfer_primitives.v
// Summary of operation
// [RULE_01] Multi-register primitive: code 00001 in bits 12..8, length low, flags high.
// [RULE_02] Both primitives in a conditional instruction cause protocol violation.
// [RULE_03] Odd operand length causes protocol violation, no transfer.
// [RULE_04] Evaluate address; scan counter grows two per extension word.
// [RULE_05] Direction 0: control or postincrement; direction 1: control alterable or predecrement.
// [RULE_06] Illegal mode: write abort mask to control register, then F-line fault.
// [RULE_07] Read 16-bit select mask; operand count is its number of ones.
// [RULE_08] Bytes moved equal operand count times operand length.
// [RULE_09] Direction 1: operand register to memory, long words when aligned; 0 reverse.
// [RULE_10] Control modes move operands at ascending addresses from the address.
// [RULE_11] Postincrement: ascending, register grows one operand each, total at end.
// [RULE_12] Predecrement: subtract operand size first; operands descend, bytes ascend.
// [RULE_13] Scan option 1 moves scan counter and status word; 0 status only.
// [RULE_14] Scan option clear: write or load 16-bit status via operand register.
// [RULE_15] Scan option, direction 0: scan counter to address register, then status.
// [RULE_16] Scan option, direction 1: load status, then 32-bit scan counter.
// [RULE_17] Direction 1 status primitive flushes prefetch, refills from scan counter.
// [RULE_18] Flow trace at start plus direction 1 arms trace, taken on completion.
// [RULE_19] Trace changes from the loaded status word apply from next instruction.
`timescale 1ns/100ps
`include "coproc_xfer_regs.vh"
`default_nettype none
module coproc_transfer_primitives (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg cir_req_q,
  output reg cir_wr_q,
  output reg [1:0] cir_sel_q,
  output reg cir_long_q,
  output reg [31:0] cir_wdata_q,
  input wire cir_ack,
  input wire [31:0] cir_rdata,
  output reg mem_req_q,
  output reg mem_wr_q,
  output reg [31:0] mem_addr_q,
  output reg mem_long_q,
  output reg [31:0] mem_wdata_q,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  input wire cop_done,
  output reg flush_q,
  output reg [31:0] refill_addr_q,
  output reg refill_super_q,
  output reg trace_take_q,
  output reg irq_q
);
  localparam S_IDLE = 4'h0;
  localparam S_DEC = 4'h1;
  localparam S_ABORT = 4'h2;
  localparam S_RSEL = 4'h3;
  localparam S_OPST = 4'h4;
  localparam S_ISS = 4'h5;
  localparam S_XA = 4'h6;
  localparam S_XB = 4'h7;
  localparam S_SC1 = 4'h8;
  localparam S_SC2 = 4'h9;
  localparam S_FIN = 4'hA;

  reg [3:0] st_q;
  reg [15:0] prim_q;
  reg [6:0] ctrl_q;
  reg [31:0] ea_q;
  reg [31:0] scan_q;
  reg [15:0] stat_q;
  reg [3:0] ist_q;
  reg [3:0] imsk_q;
  reg [3:0] ev_q;
  reg [31:0] cur_q;
  reg [7:0] rem_q;
  reg [4:0] ops_q;
  reg unit_l_q;
  reg tr_start_q;
  reg tr_pend_q;

  wire dr = prim_q[`PR_DIR];
  wire sp = prim_q[`PR_SCAN];
  wire [7:0] len = prim_q[`PR_LEN];
  wire [2:0] mode = ctrl_q[`CT_MODE];
  wire idle = (st_q == S_IDLE);
  wire acc = psel & penable & ~pready;
  wire wr_en = psel & penable & pready & pwrite;
  wire [7:0] step = unit_l_q ? `STEP_L : `STEP_W;
  wire [3:0] iclr = (wr_en && paddr == `A_INTST) ? pwdata[3:0] : 4'h0;

  function [4:0] popcnt;
    input [15:0] m;
    integer i;
    begin
      popcnt = 5'h00;
      for (i = 0; i < 16; i = i + 1) begin
        popcnt = popcnt + {4'h0, m[i]};
      end
    end
  endfunction

  // Long word only when aligned and at least four bytes remain; lengths are even
  function unit_long;
    input [7:0] rem;
    input [31:0] a;
    begin
      unit_long = (rem >= `STEP_L) && (a[1:0] == 2'h0);
    end
  endfunction

  function mode_ok;
    input d;
    input [2:0] m;
    begin
      if (d) begin
        mode_ok = (m == `M_CTLALT) || (m == `M_PRE);
      end else begin
        mode_ok = (m == `M_CTLALT) || (m == `M_CTL) || (m == `M_POST);
      end
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'h0) && (a <= `A_STATE);
    end
  endfunction

  reg [31:0] rd_v;
  always @* begin
    rd_v = `RST_W32;
    case (paddr)
      `A_PRIM: rd_v = {16'h0000, prim_q};
      `A_CTRL: rd_v = {25'h0000000, ctrl_q};
      `A_EA: rd_v = ea_q;
      `A_SCAN: rd_v = scan_q;
      `A_STAT: rd_v = {16'h0000, stat_q};
      `A_INTST: rd_v = {28'h0000000, ist_q};
      `A_INTMSK: rd_v = {28'h0000000, imsk_q};
      `A_STATE: rd_v = {14'h0000, tr_pend_q, ops_q, rem_q, st_q};
      default: rd_v = `RST_W32;
    endcase
  end

  // One wait state so read data leaves a flip-flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `RST_W32;
    end else begin
      pready <= acc;
      if (acc) begin
        prdata <= rd_v;
        pslverr <= ~mapped(paddr);
      end
    end
  end

  // Set wins over a write-one clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= 4'h0;
      imsk_q <= 4'h0;
      irq_q <= 1'b0;
    end else begin
      ist_q <= (ist_q & ~iclr) | ev_q;
      if (wr_en && paddr == `A_INTMSK) begin
        imsk_q <= pwdata[3:0];
      end
      irq_q <= |(ist_q & imsk_q);
    end
  end

  task cir_go;
    input w;
    input [1:0] s;
    input l;
    input [31:0] d;
    begin
      cir_req_q <= 1'b1;
      cir_wr_q <= w;
      cir_sel_q <= s;
      cir_long_q <= l;
      cir_wdata_q <= d;
    end
  endtask

  task mem_go;
    input w;
    input [31:0] a;
    input l;
    input [31:0] d;
    begin
      mem_req_q <= 1'b1;
      mem_wr_q <= w;
      mem_addr_q <= a;
      mem_long_q <= l;
      mem_wdata_q <= d;
    end
  endtask

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_IDLE;
      prim_q <= `RST_W16;
      ctrl_q <= 7'h00;
      ea_q <= `RST_W32;
      scan_q <= `RST_W32;
      stat_q <= `RST_W16;
      ev_q <= 4'h0;
      cur_q <= `RST_W32;
      rem_q <= 8'h00;
      ops_q <= 5'h00;
      unit_l_q <= 1'b0;
      tr_start_q <= 1'b0;
      tr_pend_q <= 1'b0;
      cir_req_q <= 1'b0;
      cir_wr_q <= 1'b0;
      cir_sel_q <= `CIR_CTRL;
      cir_long_q <= 1'b0;
      cir_wdata_q <= `RST_W32;
      mem_req_q <= 1'b0;
      mem_wr_q <= 1'b0;
      mem_addr_q <= `RST_W32;
      mem_long_q <= 1'b0;
      mem_wdata_q <= `RST_W32;
      flush_q <= 1'b0;
      refill_addr_q <= `RST_W32;
      refill_super_q <= 1'b0;
      trace_take_q <= 1'b0;
    end else begin
      ev_q <= 4'h0;
      flush_q <= 1'b0;
      trace_take_q <= 1'b0;
      if (cir_ack) begin
        cir_req_q <= 1'b0;
      end
      if (mem_ack) begin
        mem_req_q <= 1'b0;
      end
      // Trace uses the mode captured at start, never the newly loaded one
      if (tr_pend_q && cop_done) begin // [RULE_18] [RULE_19]
        tr_pend_q <= 1'b0;
        trace_take_q <= 1'b1;
        ev_q[`INT_TR] <= 1'b1;
      end
      case (st_q)
        S_IDLE: begin
          if (wr_en) begin
            case (paddr)
              `A_CTRL: ctrl_q <= pwdata[6:0];
              `A_EA: ea_q <= pwdata;
              `A_SCAN: scan_q <= pwdata;
              `A_STAT: stat_q <= pwdata[15:0];
              `A_PRIM: begin
                prim_q <= pwdata[15:0];
                tr_start_q <= (stat_q[`SW_TRACE] == `TRACE_FLOW); // [RULE_19]
                st_q <= S_DEC;
              end
              default: st_q <= S_IDLE;
            endcase
          end
        end
        S_DEC: begin
          if (ctrl_q[`CT_COND]) begin // [RULE_02]
            ev_q[`INT_PV] <= 1'b1;
            st_q <= S_IDLE;
          end else if (prim_q[`PR_CODE] == `CODE_MULTI) begin // [RULE_01]
            if (len[0]) begin // [RULE_03]
              ev_q[`INT_PV] <= 1'b1;
              st_q <= S_IDLE;
            end else begin
              scan_q <= scan_q + {28'h0000000, ctrl_q[`CT_EXT], 1'b0}; // [RULE_04]
              if (!mode_ok(dr, mode)) begin // [RULE_05]
                cir_go(1'b1, `CIR_CTRL, 1'b1, `ABORT_MASK); // [RULE_06]
                st_q <= S_ABORT;
              end else begin
                cir_go(1'b0, `CIR_RSEL, 1'b0, `RST_W32); // [RULE_07]
                st_q <= S_RSEL;
              end
            end
          end else if (prim_q[`PR_CODE] == `CODE_SRSC) begin
            if (dr) begin
              cir_go(1'b0, `CIR_OPND, 1'b0, `RST_W32); // [RULE_14] [RULE_16]
            end else if (sp) begin
              cir_go(1'b1, `CIR_IADR, 1'b1, scan_q); // [RULE_13] [RULE_15]
            end else begin
              cir_go(1'b1, `CIR_OPND, 1'b0, {16'h0000, stat_q}); // [RULE_14]
            end
            st_q <= (!dr && !sp) ? S_SC2 : S_SC1;
          end else begin
            ev_q[`INT_PV] <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        S_ABORT: begin
          if (cir_ack) begin
            ev_q[`INT_FL] <= 1'b1; // [RULE_06]
            st_q <= S_IDLE;
          end
        end
        S_RSEL: begin
          if (cir_ack) begin
            ops_q <= popcnt(cir_rdata[15:0]); // [RULE_07]
            cur_q <= ea_q; // [RULE_10]
            st_q <= (popcnt(cir_rdata[15:0]) == 5'h00 || len == 8'h00) ? S_FIN : S_OPST;
          end
        end
        S_OPST: begin
          rem_q <= len; // [RULE_08]
          if (mode == `M_PRE) begin
            ea_q <= ea_q - {24'h000000, len}; // [RULE_12]
            cur_q <= ea_q - {24'h000000, len}; // [RULE_12]
          end
          st_q <= S_ISS;
        end
        S_ISS: begin
          unit_l_q <= unit_long(rem_q, cur_q); // [RULE_09]
          if (dr) begin
            cir_go(1'b0, `CIR_OPND, unit_long(rem_q, cur_q), `RST_W32);
          end else begin
            mem_go(1'b0, cur_q, unit_long(rem_q, cur_q), `RST_W32);
          end
          st_q <= S_XA;
        end
        S_XA: begin
          if (dr && cir_ack) begin
            mem_go(1'b1, cur_q, unit_l_q, cir_rdata); // [RULE_09]
            st_q <= S_XB;
          end else if (!dr && mem_ack) begin
            cir_go(1'b1, `CIR_OPND, unit_l_q, mem_rdata); // [RULE_09]
            st_q <= S_XB;
          end
        end
        S_XB: begin
          if ((dr && mem_ack) || (!dr && cir_ack)) begin
            cur_q <= cur_q + {24'h000000, step}; // [RULE_10] [RULE_12]
            rem_q <= rem_q - step;
            if (rem_q == step) begin
              if (mode == `M_POST) begin
                ea_q <= ea_q + {24'h000000, len}; // [RULE_11]
              end
              ops_q <= ops_q - 5'h01; // [RULE_08]
              st_q <= (ops_q == 5'h01) ? S_FIN : S_OPST;
            end else begin
              st_q <= S_ISS;
            end
          end
        end
        S_SC1: begin
          if (cir_ack) begin
            if (dr) begin
              stat_q <= cir_rdata[15:0]; // [RULE_14] [RULE_16]
              if (sp) begin
                cir_go(1'b0, `CIR_IADR, 1'b1, `RST_W32); // [RULE_16]
                st_q <= S_SC2;
              end else begin
                st_q <= S_FIN;
              end
            end else begin
              cir_go(1'b1, `CIR_OPND, 1'b0, {16'h0000, stat_q}); // [RULE_15]
              st_q <= S_SC2;
            end
          end
        end
        S_SC2: begin
          if (cir_ack) begin
            if (dr) begin
              scan_q <= cir_rdata; // [RULE_16]
            end
            st_q <= S_FIN;
          end
        end
        S_FIN: begin
          ev_q[`INT_DONE] <= 1'b1;
          if (prim_q[`PR_CODE] == `CODE_SRSC && dr) begin
            flush_q <= 1'b1; // [RULE_17]
            refill_addr_q <= scan_q; // [RULE_17]
            refill_super_q <= stat_q[`SW_SUPER];
            if (tr_start_q) begin
              tr_pend_q <= 1'b1; // [RULE_18]
            end
          end
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // coproc_transfer_primitives
`default_nettype wire

//--- tb/coproc_xfer_chk_sva.sv
`timescale 1ns/100ps
`include "coproc_xfer_regs.vh"
`default_nettype none
module coproc_xfer_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic cir_req_q,
  input wire logic cir_wr_q,
  input wire logic [1:0] cir_sel_q,
  input wire logic cir_long_q,
  input wire logic [31:0] cir_wdata_q,
  input wire logic cir_ack,
  input wire logic mem_req_q,
  input wire logic [31:0] mem_addr_q,
  input wire logic mem_long_q,
  input wire logic mem_ack,
  input wire logic cop_done,
  input wire logic flush_q,
  input wire logic [31:0] refill_addr_q,
  input wire logic refill_super_q,
  input wire logic trace_take_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_cir_hold: assert property (cir_req_q && !cir_ack |=> cir_req_q && $stable(cir_sel_q) && $stable(cir_wr_q)
    && $stable(cir_wdata_q) && $stable(cir_long_q)) else $error("cir request dropped");
  a_mem_hold: assert property (mem_req_q && !mem_ack |=> mem_req_q && $stable(mem_addr_q))
    else $error("mem request dropped");
  a_abort_mask: assert property (cir_req_q && cir_wr_q && cir_sel_q == `CIR_CTRL |->
    cir_wdata_q == `ABORT_MASK && cir_long_q) else $error("bad abort write");
  a_mask_word_read: assert property (cir_req_q && cir_sel_q == `CIR_RSEL |->
    !cir_wr_q && !cir_long_q) else $error("bad select read");
  a_scan_long: assert property (cir_req_q && cir_sel_q == `CIR_IADR |-> cir_long_q)
    else $error("scan access not long");
  a_long_aligned: assert property (mem_req_q && mem_long_q |-> mem_addr_q[1:0] == 2'h0)
    else $error("misaligned long");
  a_flush_refill: assert property (flush_q |=> !flush_q && $stable(refill_addr_q)
    && $stable(refill_super_q)) else $error("flush not a pulse");
  a_trace_cause: assert property (trace_take_q |-> $past(cop_done))
    else $error("trace without completion");
  cover property (flush_q);
  cover property (trace_take_q);
  cover property (cir_req_q && cir_sel_q == `CIR_CTRL);
endmodule // coproc_xfer_chk
bind coproc_transfer_primitives coproc_xfer_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .cir_req_q(cir_req_q), .cir_wr_q(cir_wr_q), .cir_sel_q(cir_sel_q),
  .cir_long_q(cir_long_q), .cir_wdata_q(cir_wdata_q), .cir_ack(cir_ack), .mem_req_q(mem_req_q),
  .mem_addr_q(mem_addr_q), .mem_long_q(mem_long_q), .mem_ack(mem_ack), .cop_done(cop_done),
  .flush_q(flush_q), .refill_addr_q(refill_addr_q), .refill_super_q(refill_super_q),
  .trace_take_q(trace_take_q));
`default_nettype wire

//--- tb/coproc_far_side.sv
`timescale 1ns/100ps
`include "coproc_xfer_regs.vh"
`default_nettype none
module coproc_far_side (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] lat,
  input wire logic [15:0] mask,
  input wire logic [31:0] opnd,
  input wire logic [31:0] iadr,
  input wire logic cir_req,
  input wire logic cir_wr,
  input wire logic [1:0] cir_sel,
  input wire logic [31:0] cir_wdata,
  output logic cir_ack,
  output logic [31:0] cir_rdata,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic mem_long,
  input wire logic mem_wr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [3:0] cc, mc, ord;
  logic [31:0] last_iadr, last_opnd, last_maddr, mem_bytes, last_mwd, mem_wrs;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {cc, mc, ord, cir_ack, mem_ack} <= 14'h0000;
      {last_iadr, last_opnd, last_maddr, mem_bytes, last_mwd, mem_wrs, cir_rdata, mem_rdata} <= 256'h0;
    end else begin
      // Released data lines toggle so stale values never look valid
      cir_ack <= 1'b0;
      cir_rdata <= ~cir_rdata;
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cc <= (cir_req && !cir_ack) ? cc + 4'h1 : 4'h0;
      mc <= (mem_req && !mem_ack) ? mc + 4'h1 : 4'h0;
      if (cir_req && !cir_ack && cc >= lat) begin
        cir_ack <= 1'b1;
        cc <= 4'h0;
        ord <= {ord[1:0], cir_sel};
        if (cir_wr && cir_sel == `CIR_IADR) last_iadr <= cir_wdata;
        if (cir_wr && cir_sel == `CIR_OPND) last_opnd <= cir_wdata;
        cir_rdata <= cir_sel == `CIR_RSEL ? {16'h0000, mask} : cir_sel == `CIR_IADR ? iadr : opnd;
      end
      if (mem_req && !mem_ack && mc >= lat) begin
        mem_ack <= 1'b1;
        mc <= 4'h0;
        last_maddr <= mem_addr;
        mem_bytes <= mem_bytes + (mem_long ? 32'h4 : 32'h2);
        // Write data is only meaningful when the store is taken
        if (mem_wr) begin
          last_mwd <= mem_wdata;
          mem_wrs <= mem_wrs + 32'h1;
        end
        mem_rdata <= ~mem_addr;
      end
    end
  end
endmodule // coproc_far_side
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/100ps
`include "coproc_xfer_regs.vh"
`default_nettype none
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cop_done = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, b, cwd, cr, mad, mwd, mrd, rfa, iadr = 32'h0, opnd = 32'h0;
  logic pready, pslverr, creq, cwr, clg, cack, mreq, mwr, mlg, mack, flush_q, rfs, trace_take_q, irq_q;
  logic [1:0] csel;
  logic [3:0] lat = 4'h0;
  logic [15:0] mask = 16'h8421;
  int mismatches = 0, total_checks = 0, nfl = 0, ntr = 0, d, m;
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    if (flush_q) nfl++;
    if (trace_take_q) ntr++;
  end
  coproc_transfer_primitives dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cir_req_q(creq), .cir_wr_q(cwr), .cir_sel_q(csel), .cir_long_q(clg), .cir_wdata_q(cwd), .cir_ack(cack),
    .cir_rdata(cr), .mem_req_q(mreq), .mem_wr_q(mwr), .mem_addr_q(mad), .mem_long_q(mlg), .mem_wdata_q(mwd),
    .mem_ack(mack), .mem_rdata(mrd), .cop_done(cop_done), .flush_q(flush_q), .refill_addr_q(rfa),
    .refill_super_q(rfs), .trace_take_q(trace_take_q), .irq_q(irq_q));
  coproc_far_side p (.clk(pclk), .rstn(presetn), .lat(lat), .mask(mask), .opnd(opnd), .iadr(iadr),
    .cir_req(creq), .cir_wr(cwr), .cir_sel(csel), .cir_wdata(cwd), .cir_ack(cack), .cir_rdata(cr),
    .mem_req(mreq), .mem_addr(mad), .mem_long(mlg), .mem_wr(mwr), .mem_wdata(mwd), .mem_ack(mack),
    .mem_rdata(mrd));
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task ck(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin mismatches++; end_sim; end
    r = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    ck(r, e);
  endtask
  task run(input logic [15:0] pw, input logic [31:0] c);
    int i;
    apb(1'b1, `A_CTRL, c);
    apb(1'b1, `A_PRIM, {16'h0000, pw});
    for (i = 0; i < 100; i++) begin
      apb(1'b0, `A_STATE, 32'h0);
      if (r[3:0] === 4'h0) break;
    end
    if (i == 100) begin mismatches++; end_sim; end
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(`A_STAT, 32'h0);
    apb(1'b1, `A_INTMSK, 32'hF);
    apb(1'b0, 8'h20, 32'h0);
    ck({31'h0, err}, 32'h1);
    $display("test registers done");
    apb(1'b1, `A_EA, 32'h100);
    apb(1'b1, `A_SCAN, 32'h1000);
    b = p.mem_bytes;
    run({3'b000, `CODE_MULTI, 8'h06}, {25'h0, 3'h2, `M_POST, 1'b0});
    rc(`A_EA, 32'h118);
    rc(`A_SCAN, 32'h1004);
    ck(p.mem_bytes - b, 32'h18);
    ck(p.last_maddr, 32'h114);
    ck(p.last_opnd, 32'hFFFFFEEB);
    rc(`A_INTST, 32'h1);
    ck({31'h0, irq_q}, 32'h1);
    apb(1'b1, `A_INTMSK, 32'h0);
    @(posedge pclk);
    ck({31'h0, irq_q}, 32'h0);
    apb(1'b1, `A_INTMSK, 32'hF);
    apb(1'b1, `A_INTST, 32'h1);
    rc(`A_INTST, 32'h0);
    $display("test postincrement done");
    lat <= 4'h3;
    opnd <= 32'h13579BDF;
    mask <= 16'h0003;
    apb(1'b1, `A_EA, 32'h200);
    b = p.mem_bytes;
    run({3'b001, `CODE_MULTI, 8'h0C}, {28'h0, `M_PRE, 1'b0});
    rc(`A_EA, 32'h1E8);
    ck(p.mem_bytes - b, 32'h18);
    ck(p.last_maddr, 32'h1F0);
    ck(p.last_mwd, 32'h13579BDF);
    ck(p.mem_wrs, 32'h6);
    apb(1'b1, `A_INTST, 32'hF);
    lat <= 4'h0;
    mask <= 16'h0000;
    $display("test predecrement done");
    for (d = 0; d < 2; d++) begin
      for (m = 0; m < 4; m++) begin
        run({2'b00, d[0], `CODE_MULTI, 8'h02}, {28'h0, m[2:0], 1'b0});
        rc(`A_INTST, (8'b1001_0111 >> (d * 4 + m)) & 1 ? 32'h1 : 32'h4);
        apb(1'b1, `A_INTST, 32'hF);
      end
    end
    for (d = 0; d < 3; d++) begin
      run(d == 1 ? {3'b0, `CODE_SRSC, 8'h00} : {3'b0, `CODE_MULTI, d == 2 ? 8'h03 : 8'h02},
        {28'h0, `M_CTL, d != 2});
      rc(`A_INTST, 32'h2);
      apb(1'b1, `A_INTST, 32'hF);
    end
    $display("test refusals done");
    apb(1'b1, `A_STAT, 32'h2345);
    apb(1'b1, `A_SCAN, 32'h4000);
    run({3'b000, `CODE_SRSC, 8'h01}, 32'h0);
    ck(p.last_iadr, 32'h4000);
    ck({16'h0, p.last_opnd[15:0]}, 32'h2345);
    ck({28'h0, p.ord}, 32'hE);
    apb(1'b1, `A_STAT, 32'h0123);
    run({3'b000, `CODE_SRSC, 8'h00}, 32'h0);
    ck({16'h0, p.last_opnd[15:0]}, 32'h0123);
    ck({p.last_iadr[31:2], p.ord[1:0]}, 32'h4002);
    ck(nfl, 32'h0);
    apb(1'b1, `A_INTST, 32'hF);
    $display("test status write done");
    apb(1'b1, `A_STAT, 32'h4000);
    opnd <= 32'h2000;
    iadr <= 32'h8000;
    run({3'b001, `CODE_SRSC, 8'h01}, 32'h0);
    rc(`A_STAT, 32'h2000);
    rc(`A_SCAN, 32'h8000);
    ck({28'h0, p.ord}, 32'hB);
    ck({nfl[7:0], rfa[23:0]}, 32'h01008000);
    ck({31'h0, rfs}, 32'h1);
    rc(`A_INTST, 32'h1);
    cop_done <= 1'b1;
    @(posedge pclk);
    cop_done <= 1'b0;
    repeat (3) @(posedge pclk);
    ck(ntr, 32'h1);
    rc(`A_INTST, 32'h9);
    apb(1'b1, `A_INTST, 32'hF);
    opnd <= 32'h4000;
    run({3'b001, `CODE_SRSC, 8'h00}, 32'h0);
    rc(`A_STAT, 32'h4000);
    cop_done <= 1'b1;
    @(posedge pclk);
    cop_done <= 1'b0;
    repeat (3) @(posedge pclk);
    ck({ntr[7:0], 23'h0, rfs}, 32'h01000000);
    $display("test status load done");
    end_sim;
  end
endmodule // testbench
`default_nettype wire
